/* hdl/cfs_pkg.sv */
package cfs_pkg;
    // clock and time base
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint SEC_NS = 1_000_000_000;
    localparam longint MINUTE_NS = 60 * SEC_NS;
    localparam longint MINUTE_CYCLES_DFLT = MINUTE_NS / CLK_PERIOD_NS;
    localparam longint DISCHARGE_MIN = 5;
    localparam longint DISCHARGE_CYCLES_DFLT =
        DISCHARGE_MIN * MINUTE_CYCLES_DFLT;
    localparam int TICK_W = 36;
    localparam int HOUR_MIN = 60;

    // alternation cycle and quotas, counted in minutes
    localparam int RT_W = 10;
    localparam int CYCLE_H = 10;
    localparam int QUOTA1_H = 6;
    localparam int QUOTA2_H = 4;
    localparam logic [RT_W-1:0] CYCLE_MIN_DFLT = RT_W'(CYCLE_H * HOUR_MIN);
    localparam logic [RT_W-1:0] QUOTA1_MIN_DFLT = RT_W'(QUOTA1_H * HOUR_MIN);
    localparam logic [RT_W-1:0] QUOTA2_MIN_DFLT = RT_W'(QUOTA2_H * HOUR_MIN);
    localparam logic [RT_W-1:0] RT_ZERO = 10'h000;
    localparam logic [RT_W-1:0] RT_ONE = 10'h001;

    // synchronised pin positions
    localparam int PIN_W = 8;
    localparam int PIN_BREAKER = 0;
    localparam int PIN_DRIVE_RUN = 1;
    localparam int PIN_FAIL1 = 2;
    localparam int PIN_FAIL2 = 3;
    localparam int PIN_AIRFLOW = 4;
    localparam int PIN_FILTER = 5;
    localparam int PIN_DC_LOW = 6;
    localparam int PIN_ENERGIZED = 7;
    localparam logic [PIN_W-1:0] PIN_RST = 8'h00;

    // ec fan speed command
    localparam int SPD_W = 8;
    localparam logic [SPD_W-1:0] SPD_ZERO = 8'h00;
    localparam logic [SPD_W-1:0] SPD_FULL = 8'hff;

    // filter clogged reaction codes
    localparam logic [1:0] FILT_ALARM = 2'h0;
    localparam logic [1:0] FILT_SHUTDOWN = 2'h1;
    localparam logic [1:0] FILT_SPEEDUP = 2'h2;

    typedef enum logic [1:0] {
        COOL_OFF = 2'b00,
        COOL_ON = 2'b01,
        COOL_DISCH = 2'b10
    } cfs_cool_type;
endpackage

/* hdl/cfs_rt_if.sv */
`timescale 1ns/1ps
interface cfs_rt_if
    import cfs_pkg::*;
    ();
    logic tick;
    logic run;
    logic clear;
    logic [RT_W-1:0] quota;
    logic [RT_W-1:0] count;
    logic expired;
    modport unit (input tick, input run, input clear, input quota,
                  output count, output expired);
    modport ctrl (output tick, output run, output clear, output quota,
                  input count, input expired);
endinterface

/* hdl/cfs_runtime.sv */
`timescale 1ns/1ps
module cfs_runtime
    import cfs_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    cfs_rt_if.unit rt
);
    logic [RT_W-1:0] count_ff;
    logic [RT_W-1:0] nxt_count;
    wire step = rt.tick & rt.run & ~rt.expired;

    // minutes of runtime, advancing only while the fan runs
    assign nxt_count = rt.clear ? RT_ZERO :
                       step ? count_ff + RT_ONE : count_ff;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            count_ff <= RT_ZERO;
        else
            count_ff <= nxt_count;
    end

    assign rt.count = count_ff;
    assign rt.expired = (count_ff >= rt.quota);
endmodule

/* hdl/cfs_supervisor.sv */
`timescale 1ns/1ps
// Operation
// - cooling starts when breaker closes
// - discharge delay before fans stop
// - ac fans alternate in repeating cycle
// - programmable quotas, default six and four
// - fan one expires, fan two starts
// - intermittent: due fan follows drive pattern
// - one ac fan failed: other runs continuously
// - healthy redundant ec fans both run reduced speed
// - ec fan failed: survivor speeds up
// - ec speed follows inverter current
// - ac fans only on/off, no speed
// - non-redundant airflow trip: alarm, shutdown
// - redundant airflow trip: standby, then shutdown
// - airflow switch used with ac fans only
// - filter trip: alarm plus programmable reaction
// - heaters on exactly while cooling off
// - door locks held while energised
// - doors release only below 50 V
module cfs_supervisor
    import cfs_pkg::*;
#(
    parameter longint MINUTE_CYCLES = MINUTE_CYCLES_DFLT,
    parameter longint DISCHARGE_CYCLES = DISCHARGE_CYCLES_DFLT
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic main_breaker_closed,
    input wire logic drive_running,
    input wire logic fan1_failed,
    input wire logic fan2_failed,
    input wire logic airflow_switch_trip,
    input wire logic filter_switch_trip,
    input wire logic dc_link_below_50v,
    input wire logic drive_energized,
    input wire logic cfg_redundant,
    input wire logic cfg_ec_fans,
    input wire logic cfg_intermittent,
    input wire logic [RT_W-1:0] cfg_cycle_min,
    input wire logic [RT_W-1:0] cfg_quota1_min,
    input wire logic [RT_W-1:0] cfg_quota2_min,
    input wire logic [1:0] cfg_filter_reaction,
    input wire logic [SPD_W-1:0] cfg_ec_min_speed,
    input wire logic [SPD_W-1:0] inverter_current,
    input wire logic ack_airflow_alarm,
    input wire logic ack_filter_alarm,
    output logic cooling_active,
    output logic [1:0] ac_fan_contactor,
    output logic [1:0] ec_fan_enable,
    output logic [SPD_W-1:0] ec_fan1_speed,
    output logic [SPD_W-1:0] ec_fan2_speed,
    output logic space_heater_on,
    output logic door_lock_engaged,
    output logic drive_shutdown,
    output logic airflow_pressure_alarm,
    output logic filter_clogged_alarm,
    output logic airflow_alarm_event,
    output logic filter_alarm_event
);
    logic [PIN_W-1:0] pin_s1_ff;
    logic [PIN_W-1:0] pin_s2_ff;
    logic [PIN_W-1:0] pin_prev_ff;
    logic [TICK_W-1:0] min_cnt_ff;
    logic tick_ff;
    cfs_cool_type state_ff;
    cfs_cool_type nxt_state;
    logic [TICK_W-1:0] dis_cnt_ff;
    logic [RT_W-1:0] cyc_ff;
    logic sel_ff;
    logic [1:0] trip_bad_ff;
    logic air_alarm_ff;
    logic filt_alarm_ff;
    logic air_evt_ff;
    logic filt_evt_ff;
    logic cool_ff;
    logic [1:0] contactor_ff;
    logic [1:0] ec_en_ff;
    logic [SPD_W-1:0] spd1_ff;
    logic [SPD_W-1:0] spd2_ff;
    logic heater_ff;
    logic door_ff;
    logic shutdown_ff;

    // two-stage synchronisers for all pins
    wire [PIN_W-1:0] pin_raw = {drive_energized, dc_link_below_50v,
        filter_switch_trip, airflow_switch_trip, fan2_failed,
        fan1_failed, drive_running, main_breaker_closed};

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pin_s1_ff <= PIN_RST;
            pin_s2_ff <= PIN_RST;
            pin_prev_ff <= PIN_RST;
        end
        else
        begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            pin_prev_ff <= pin_s2_ff;
        end
    end

    wire breaker = pin_s2_ff[PIN_BREAKER];
    wire drive_run = pin_s2_ff[PIN_DRIVE_RUN];
    wire [1:0] fan_fail = {pin_s2_ff[PIN_FAIL2], pin_s2_ff[PIN_FAIL1]};
    wire air_rise = pin_s2_ff[PIN_AIRFLOW] & ~pin_prev_ff[PIN_AIRFLOW];
    wire filt_rise = pin_s2_ff[PIN_FILTER] & ~pin_prev_ff[PIN_FILTER];
    wire dc_low = pin_s2_ff[PIN_DC_LOW];
    wire energized = pin_s2_ff[PIN_ENERGIZED];

    // minute time base
    wire min_wrap = (min_cnt_ff == TICK_W'(MINUTE_CYCLES - 1));
    wire [TICK_W-1:0] nxt_min_cnt =
        min_wrap ? '0 : min_cnt_ff + TICK_W'(1);

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            min_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            min_cnt_ff <= nxt_min_cnt;
            tick_ff <= min_wrap;
        end
    end

    // cooling on/off with discharge delay
    wire dis_done = (dis_cnt_ff == TICK_W'(DISCHARGE_CYCLES - 1));
    wire [TICK_W-1:0] nxt_dis_cnt = (state_ff == COOL_DISCH) ?
        dis_cnt_ff + TICK_W'(1) : '0;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            COOL_OFF:
                if (breaker)
                    nxt_state = COOL_ON;
            COOL_ON:
                if (!breaker)
                    nxt_state = COOL_DISCH;
            COOL_DISCH:
                if (breaker)
                    nxt_state = COOL_ON;
                else if (dis_done)
                    nxt_state = COOL_OFF;
            default:
                nxt_state = COOL_OFF;
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= COOL_OFF;
            dis_cnt_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            dis_cnt_ff <= nxt_dis_cnt;
        end
    end

    wire cooling_on = (state_ff != COOL_OFF);
    wire nxt_cooling_on = (nxt_state != COOL_OFF);

    // ac fan alternation
    wire ac_alt = cooling_on & cfg_redundant & ~cfg_ec_fans;
    wire [1:0] fan_bad = fan_fail | trip_bad_ff;
    wire one_bad = ^fan_bad;
    wire both_bad = &fan_bad;
    wire [RT_W-1:0] cyc_len =
        (cfg_cycle_min == RT_ZERO) ? CYCLE_MIN_DFLT : cfg_cycle_min;
    wire [RT_W-1:0] quota1 =
        (cfg_quota1_min == RT_ZERO) ? QUOTA1_MIN_DFLT : cfg_quota1_min;
    wire [RT_W-1:0] quota2 =
        (cfg_quota2_min == RT_ZERO) ? QUOTA2_MIN_DFLT : cfg_quota2_min;
    wire cycle_end = ac_alt & tick_ff & (cyc_ff == cyc_len - RT_ONE);
    wire pattern = ~cfg_intermittent | drive_run;
    wire [1:0] sel_dec = {sel_ff, ~sel_ff};
    wire [1:0] alt_run = cooling_on & pattern ? sel_dec : 2'b00;
    wire [1:0] fail_run = cooling_on ? ~fan_bad : 2'b00;
    wire [1:0] red_run = one_bad ? fail_run :
                         both_bad ? 2'b00 : alt_run;
    wire [1:0] single_run = {1'b0, cooling_on & ~fan_bad[0]};
    wire [1:0] ac_run = cfg_ec_fans ? 2'b00 :
                        cfg_redundant ? red_run : single_run;
    wire [1:0] expired;
    wire sel_exp = sel_ff ? expired[1] : expired[0];
    wire oth_exp = sel_ff ? expired[0] : expired[1];
    wire handover = ac_alt & ~one_bad & ~both_bad & sel_exp & ~oth_exp;
    wire [RT_W-1:0] nxt_cyc = cycle_end ? RT_ZERO :
        (ac_alt & tick_ff) ? cyc_ff + RT_ONE : cyc_ff;
    wire nxt_sel = cycle_end ? 1'b0 : handover ? ~sel_ff : sel_ff;

    cfs_rt_if rt_if [2] ();

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_rt
            assign rt_if[g].tick = tick_ff;
            assign rt_if[g].run = ac_run[g];
            assign rt_if[g].clear = cycle_end;
            assign rt_if[g].quota = (g == 0) ? quota1 : quota2;
            assign expired[g] = rt_if[g].expired;
            cfs_runtime u_rt (
                .clock(clock),
                .reset(reset),
                .rt(rt_if[g])
            );
        end
    endgenerate

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cyc_ff <= RT_ZERO;
            sel_ff <= 1'b0;
        end
        else
        begin
            cyc_ff <= nxt_cyc;
            sel_ff <= nxt_sel;
        end
    end

    // airflow and filter supervision
    wire air_set = air_rise & ~cfg_ec_fans;
    wire filt_set = filt_rise;
    wire [1:0] trip_hit = (air_set & cfg_redundant) ? ac_run : 2'b00;
    wire [1:0] nxt_trip_bad =
        trip_hit | (ack_airflow_alarm ? 2'b00 : trip_bad_ff);
    wire nxt_air = air_set | (air_alarm_ff & ~ack_airflow_alarm);
    wire nxt_filt = filt_set | (filt_alarm_ff & ~ack_filter_alarm);
    wire filt_stop = filt_alarm_ff & (cfg_filter_reaction == FILT_SHUTDOWN);
    wire filt_fast = filt_alarm_ff & (cfg_filter_reaction == FILT_SPEEDUP);
    wire nxt_shutdown =
        (~cfg_redundant & ~cfg_ec_fans & air_alarm_ff) |
        (cfg_redundant & both_bad) |
        (~cfg_redundant & fan_bad[0]) |
        filt_stop;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            trip_bad_ff <= 2'b00;
            air_alarm_ff <= 1'b0;
            filt_alarm_ff <= 1'b0;
            air_evt_ff <= 1'b0;
            filt_evt_ff <= 1'b0;
            shutdown_ff <= 1'b0;
        end
        else
        begin
            trip_bad_ff <= nxt_trip_bad;
            air_alarm_ff <= nxt_air;
            filt_alarm_ff <= nxt_filt;
            air_evt_ff <= air_set;
            filt_evt_ff <= filt_set;
            shutdown_ff <= nxt_shutdown;
        end
    end

    // ec fan speed from inverter current
    wire [SPD_W-1:0] half_cur = {1'b0, inverter_current[SPD_W-1:1]};
    wire [SPD_W-1:0] spd_shared = (half_cur > cfg_ec_min_speed) ?
        half_cur : cfg_ec_min_speed;
    wire [SPD_W-1:0] spd_single = (inverter_current > cfg_ec_min_speed) ?
        inverter_current : cfg_ec_min_speed;
    wire ec_one_bad = ^fan_fail;
    wire [SPD_W-1:0] spd_run = filt_fast ? SPD_FULL :
        (cfg_redundant & ~ec_one_bad) ? spd_shared : spd_single;
    wire [1:0] ec_fitted = {cfg_redundant, 1'b1};
    wire [1:0] ec_run = (cfg_ec_fans & cooling_on) ?
        (ec_fitted & ~fan_fail) : 2'b00;
    wire [SPD_W-1:0] nxt_spd1 = ec_run[0] ? spd_run : SPD_ZERO;
    wire [SPD_W-1:0] nxt_spd2 = ec_run[1] ? spd_run : SPD_ZERO;
    wire nxt_door = energized | ~dc_low;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            cool_ff <= 1'b0;
            contactor_ff <= 2'b00;
            ec_en_ff <= 2'b00;
            spd1_ff <= SPD_ZERO;
            spd2_ff <= SPD_ZERO;
            heater_ff <= 1'b1;
            door_ff <= 1'b1;
        end
        else
        begin
            cool_ff <= nxt_cooling_on;
            contactor_ff <= ac_run;
            ec_en_ff <= ec_run;
            spd1_ff <= nxt_spd1;
            spd2_ff <= nxt_spd2;
            heater_ff <= ~nxt_cooling_on;
            door_ff <= nxt_door;
        end
    end

    assign cooling_active = cool_ff;
    assign ac_fan_contactor = contactor_ff;
    assign ec_fan_enable = ec_en_ff;
    assign ec_fan1_speed = spd1_ff;
    assign ec_fan2_speed = spd2_ff;
    assign space_heater_on = heater_ff;
    assign door_lock_engaged = door_ff;
    assign drive_shutdown = shutdown_ff;
    assign airflow_pressure_alarm = air_alarm_ff;
    assign filter_clogged_alarm = filt_alarm_ff;
    assign airflow_alarm_event = air_evt_ff;
    assign filter_alarm_event = filt_evt_ff;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    property p_start;
        state_ff == COOL_OFF && breaker |=> cool_ff && !heater_ff;
    endproperty
    a_start: assert property (p_start)
        else $error("cooling did not start on breaker close");

    property p_discharge;
        state_ff == COOL_DISCH && !breaker && dis_done
            |=> state_ff == COOL_OFF && !cool_ff;
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("cooling not off after discharge delay");

    property p_cycle;
        cycle_end |=> sel_ff == 1'b0 && cyc_ff == RT_ZERO
            && rt_if[0].count == RT_ZERO && rt_if[1].count == RT_ZERO;
    endproperty
    a_cycle: assert property (p_cycle)
        else $error("new cycle did not restart fan one");

    property p_handover;
        handover && !cycle_end && !sel_ff |=> sel_ff ##1 !contactor_ff[0];
    endproperty
    a_handover: assert property (p_handover)
        else $error("fan one not handed over at quota");

    property p_failover;
        ac_alt && one_bad |=> contactor_ff == $past(~fan_bad);
    endproperty
    a_failover: assert property (p_failover)
        else $error("surviving ac fan not running");

    property p_ec_both;
        cfg_ec_fans && cfg_redundant && cooling_on && fan_fail == 2'b00
            && !filt_fast |=> ec_en_ff == 2'b11 && spd1_ff == spd2_ff;
    endproperty
    a_ec_both: assert property (p_ec_both)
        else $error("healthy ec fans not sharing speed");

    property p_ec_single;
        cfg_ec_fans && cfg_redundant && cooling_on && fan_fail == 2'b10
            && !filt_fast |=> spd1_ff == $past(spd_single) && spd2_ff == 8'h00;
    endproperty
    a_ec_single: assert property (p_ec_single)
        else $error("surviving ec fan not sped up");

    property p_ac_nospeed;
        !cfg_ec_fans |=> spd1_ff == 8'h00 && spd2_ff == 8'h00;
    endproperty
    a_ac_nospeed: assert property (p_ac_nospeed)
        else $error("ac fan given a speed command");

    property p_air_stop;
        air_set && !cfg_redundant |=> air_alarm_ff && air_evt_ff
            ##1 drive_shutdown;
    endproperty
    a_air_stop: assert property (p_air_stop)
        else $error("airflow trip did not shut drive down");

    property p_door;
        energized || !dc_low |=> door_ff;
    endproperty
    a_door: assert property (p_door)
        else $error("door released while charged");

    property p_sticky;
        air_alarm_ff && !ack_airflow_alarm |=> air_alarm_ff;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("airflow alarm dropped without ack");

    c_disch: cover property (state_ff == COOL_DISCH ##1 state_ff == COOL_OFF);
    c_handover: cover property (handover);
    c_failover: cover property (ac_alt && one_bad);
    c_shutdown: cover property ($rose(shutdown_ff));
endmodule

/* tb/cfs_plant.sv */
`timescale 1ns/1ps
module cfs_plant
(
    input wire logic clock,
    input wire logic breaker_cmd,
    input wire logic block_cmd,
    input wire logic [1:0] fail_cmd,
    output logic breaker_closed,
    output logic airflow_trip,
    output logic [1:0] fan_failed
);
    // breaker auxiliary contact lags the close command
    logic [2:0] brk_ff = 3'h0;
    always_ff @(posedge clock)
    begin
        brk_ff <= {brk_ff[1:0], breaker_cmd};
    end
    assign breaker_closed = brk_ff[2];
    // blocked air path drops pressure, switch trips
    assign airflow_trip = block_cmd;
    // fan fault contacts
    assign fan_failed = fail_cmd;
endmodule

/* tb/cooling_fan_supervisor_test.sv */
`timescale 1ns/1ps
module cooling_fan_supervisor_test
    import cfs_pkg::*;
;
    typedef struct packed {
        logic r;
        logic [1:0] f;
        logic [7:0] cur, mn;
        logic [1:0] en;
        logic [7:0] s1, s2;
    } cfs_row_type;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic breaker_cmd = 1'b0, block_cmd = 1'b0, drive_running = 1'b1;
    logic [1:0] fail_cmd = 2'h0, reaction = 2'h0;
    logic filter_trip = 1'b0, dc_low = 1'b0, energized = 1'b1;
    logic red = 1'b1, ec = 1'b1, inter = 1'b0, ack_air = 1'b0;
    logic ack_filt = 1'b0;
    logic [SPD_W-1:0] min_spd = 8'h20, current = 8'h80;
    logic breaker, airflow, cool, heat, lock, shut, air_alm, filt_alm;
    logic air_evt, filt_evt;
    logic [1:0] failed, ac_con, ec_en;
    logic [SPD_W-1:0] spd1, spd2;
    logic [9:0] obs;
    int failures = 0, num_checks = 0, air_n = 0, filt_n = 0;
    cfs_row_type rows [5] = '{
        '{1'b1, 2'h0, 8'h80, 8'h20, 2'h3, 8'h40, 8'h40},
        '{1'b1, 2'h0, 8'h20, 8'h30, 2'h3, 8'h30, 8'h30},
        '{1'b1, 2'h1, 8'h80, 8'h20, 2'h2, 8'h00, 8'h80},
        '{1'b1, 2'h2, 8'h90, 8'h20, 2'h1, 8'h90, 8'h00},
        '{1'b0, 2'h0, 8'h60, 8'h10, 2'h1, 8'h60, 8'h00}};

    assign obs = {cool, ac_con, ec_en, heat, lock, shut, air_alm, filt_alm};

    initial forever #5 clock = ~clock;

    always @(posedge clock)
    begin
        if (air_evt === 1'b1) air_n <= air_n + 1;
        if (filt_evt === 1'b1) filt_n <= filt_n + 1;
    end

    cfs_plant plant_u (.clock(clock), .breaker_cmd(breaker_cmd),
        .block_cmd(block_cmd), .fail_cmd(fail_cmd),
        .breaker_closed(breaker), .airflow_trip(airflow),
        .fan_failed(failed));

    cfs_supervisor #(.MINUTE_CYCLES(20), .DISCHARGE_CYCLES(100)) dut_u (
        .clock(clock), .reset(reset), .main_breaker_closed(breaker),
        .drive_running(drive_running), .fan1_failed(failed[0]),
        .fan2_failed(failed[1]), .airflow_switch_trip(airflow),
        .filter_switch_trip(filter_trip), .dc_link_below_50v(dc_low),
        .drive_energized(energized), .cfg_redundant(red),
        .cfg_ec_fans(ec), .cfg_intermittent(inter),
        .cfg_cycle_min(10'h00a), .cfg_quota1_min(10'h006),
        .cfg_quota2_min(10'h004), .cfg_filter_reaction(reaction),
        .cfg_ec_min_speed(min_spd), .inverter_current(current),
        .ack_airflow_alarm(ack_air), .ack_filter_alarm(ack_filt),
        .cooling_active(cool), .ac_fan_contactor(ac_con),
        .ec_fan_enable(ec_en), .ec_fan1_speed(spd1),
        .ec_fan2_speed(spd2), .space_heater_on(heat),
        .door_lock_engaged(lock), .drive_shutdown(shut),
        .airflow_pressure_alarm(air_alm),
        .filter_clogged_alarm(filt_alm), .airflow_alarm_event(air_evt),
        .filter_alarm_event(filt_evt));

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask

    // poll masked outputs until match or limit, end on an edge
    task automatic wait_obs(string what, logic [9:0] m, logic [9:0] v,
                            int lim);
        int n;
        n = 0;
        #1;
        while ((obs & m) !== v && n < lim)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check(what, 16'(obs & m), 16'(v));
        @(posedge clock);
    endtask

    // masked outputs must hold every cycle of the span
    task automatic hold_obs(string what, logic [9:0] m, logic [9:0] v,
                            int cyc);
        logic [9:0] bad;
        bad = 10'h000;
        repeat (cyc)
        begin
            @(posedge clock);
            #1;
            bad = bad | ((obs & m) ^ v);
        end
        check(what, 16'(bad), 16'h0000);
        @(posedge clock);
    endtask

    task automatic do_reset();
        reset <= 1'b1;
        tick(3);
        #1;
        check("reset_obs", 16'(obs), 16'h0018);
        check("reset_spd", {spd1, spd2}, 16'h0000);
        tick(2);
        reset <= 1'b0;
        tick(4);
    endtask

    task automatic pulse_ack(logic air);
        ack_air <= air;
        ack_filt <= ~air;
        tick(1);
        ack_air <= 1'b0;
        ack_filt <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (8000) @(posedge clock);
        failures++;
        wrap_up();
    end

    initial
    begin
        do_reset();
        breaker_cmd <= 1'b1;
        wait_obs("ec_cool_on", 10'h210, 10'h200, 20);
        foreach (rows[i])
        begin
            red <= rows[i].r;
            fail_cmd <= rows[i].f;
            current <= rows[i].cur;
            min_spd <= rows[i].mn;
            tick(10);
            check("ec_en", 16'(ec_en), 16'(rows[i].en));
            check("ec_spd", {spd1, spd2}, {rows[i].s1, rows[i].s2});
        end
        red <= 1'b1;
        fail_cmd <= 2'h0;
        current <= 8'h80;
        min_spd <= 8'h20;
        block_cmd <= 1'b1;
        hold_obs("ec_no_air", 10'h006, 10'h000, 12);
        block_cmd <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            reaction <= 2'(k);
            filter_trip <= 1'b1;
            wait_obs("filt_alarm", 10'h001, 10'h001, 12);
            tick(3);
            check("filt_shut", 16'(shut), 16'(k == 1));
            check("filt_spd", 16'(spd1), k == 2 ? 16'h00ff : 16'h0040);
            filter_trip <= 1'b0;
            pulse_ack(1'b0);
            wait_obs("filt_ack", 10'h005, 10'h000, 12);
        end
        check("filt_events", 16'(filt_n), 16'h0003);
        breaker_cmd <= 1'b0;
        hold_obs("discharge", 10'h200, 10'h200, 90);
        wait_obs("cool_off", 10'h270, 10'h010, 30);
        ec <= 1'b0;
        do_reset();
        breaker_cmd <= 1'b1;
        wait_obs("ac_on", 10'h390, 10'h280, 20);
        #1;
        check("ac_spd", {spd1, spd2}, 16'h0000);
        hold_obs("fan1_run", 10'h180, 10'h080, 95);
        wait_obs("fan2_on", 10'h180, 10'h100, 50);
        hold_obs("fan2_run", 10'h180, 10'h100, 60);
        wait_obs("wrap", 10'h180, 10'h080, 50);
        hold_obs("fan1_again", 10'h180, 10'h080, 60);
        block_cmd <= 1'b1;
        wait_obs("air_redund", 10'h186, 10'h102, 12);
        block_cmd <= 1'b0;
        hold_obs("air_sticky", 10'h002, 10'h002, 10);
        block_cmd <= 1'b1;
        wait_obs("standby_fail", 10'h004, 10'h004, 12);
        block_cmd <= 1'b0;
        tick(4);
        pulse_ack(1'b1);
        wait_obs("air_ack", 10'h006, 10'h000, 12);
        check("air_events", 16'(air_n), 16'h0002);
        inter <= 1'b1;
        drive_running <= 1'b0;
        wait_obs("inter_off", 10'h180, 10'h000, 12);
        drive_running <= 1'b1;
        tick(8);
        check("inter_on", 16'(ac_con), 16'h0001);
        inter <= 1'b0;
        fail_cmd <= 2'h1;
        wait_obs("fail1", 10'h180, 10'h100, 12);
        hold_obs("fail1_hold", 10'h180, 10'h100, 250);
        fail_cmd <= 2'h2;
        wait_obs("fail2", 10'h180, 10'h080, 12);
        fail_cmd <= 2'h0;
        red <= 1'b0;
        tick(4);
        block_cmd <= 1'b1;
        wait_obs("air_single", 10'h006, 10'h006, 12);
        block_cmd <= 1'b0;
        pulse_ack(1'b1);
        wait_obs("air_clear", 10'h006, 10'h000, 12);
        energized <= 1'b0;
        hold_obs("door_dc_high", 10'h008, 10'h008, 10);
        dc_low <= 1'b1;
        wait_obs("door_free", 10'h008, 10'h000, 10);
        energized <= 1'b1;
        wait_obs("door_energ", 10'h008, 10'h008, 10);
        wrap_up();
    end
endmodule
